// File: ceq_pkg.sv
// Package with constants and types for the channel error queue and frame recovery block
//
// Contract
// - Sixteen-deep error FIFO and interrupt per channel
// - Record is 8-bit code plus 24-bit info
// - Rx overrun at frame start logs 0x01
// - Rx overrun mid-frame logs 0x02
// - Rx bitmap exceeds size logs 0x03
// - Rx frame size below 8 logs 0x05
// - Tx config id mismatch logs 0x10
// - Tx underrun at frame start logs 0x11
// - Tx underrun mid-frame logs 0x12
// - Tx bitmap exceeds size logs 0x13
// - Tx frame size below 8 logs 0x15
// - Bus status nonzero logs 0xF0/0xF8 plus status
// - Append record, full drops and sets overflow
// - Overflow drops all until software clears
// - Head read keeps entry, write pops
// - Count register plus queue control register
// - Empty queue head reads zero
// - Early frame sync is ignored
// - Extra clocks after frame are ignored
// - Awaited sync restarts bit counter with delay
// - After clock outage finish frame, then resync
`default_nettype none

package ceq_pkg;
    // Record layout
    localparam int CODE_W = 8;
    localparam int INFO_W = 24;
    localparam int REC_W = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 5;
    // Fault codes
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_RX_OVR_START = 8'h01;
    localparam logic [7:0] CODE_RX_OVR_MID = 8'h02;
    localparam logic [7:0] CODE_RX_SIZE_OVR = 8'h03;
    localparam logic [7:0] CODE_RX_SIZE_MIN = 8'h05;
    localparam logic [7:0] CODE_TX_CID_MISM = 8'h10;
    localparam logic [7:0] CODE_TX_UND_START = 8'h11;
    localparam logic [7:0] CODE_TX_UND_MID = 8'h12;
    localparam logic [7:0] CODE_TX_SIZE_OVR = 8'h13;
    localparam logic [7:0] CODE_TX_SIZE_MIN = 8'h15;
    localparam logic [7:0] CODE_BUS_RD_BASE = 8'hf0;
    localparam logic [7:0] CODE_BUS_WR_BASE = 8'hf8;
    localparam int NUM_SRC = 11;
    // Minimum frame size
    localparam logic [15:0] MIN_FRAME_SIZE = 16'h0008;
    // Wishbone map, byte addresses
    localparam logic [7:0] ADDR_QCTRL = 8'h00;
    localparam logic [7:0] ADDR_QCOUNT = 8'h04;
    localparam logic [7:0] ADDR_QHEAD = 8'h08;
    localparam logic [7:0] ADDR_SERCTL = 8'h0c;
    localparam logic [7:0] ADDR_SERSTAT = 8'h10;
    localparam int QCTRL_OVF_BIT = 0;
    localparam int SERCTL_DLY_LSB = 0;
    localparam int SERCTL_BITS_LSB = 8;
    // Reset values
    localparam logic [1:0] RST_DATA_DELAY = 2'h0;
    localparam logic [10:0] RST_FRAME_BITS = 11'h400;
    // Frame tracker states, gray along the path
    typedef enum logic [1:0] {
        CEQ_WAIT_SYNC = 2'b00,
        CEQ_DELAY = 2'b01,
        CEQ_RUN = 2'b11,
        CEQ_FLUSH = 2'b10
    } ceq_frame_state_t;
    // Fault record
    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic [INFO_W-1:0] info;
    } ceq_rec_t;
    // Fault inputs from the channel logic
    typedef struct packed {
        logic rx_ovr_start;
        logic rx_ovr_mid;
        logic rx_size_ovr;
        logic rx_size_small;
        logic tx_cid_fetch;
        logic tx_und_start;
        logic tx_und_mid;
        logic tx_size_ovr;
        logic tx_size_small;
        logic bus_rd_done;
        logic bus_wr_done;
        logic [2:0] bus_rd_status;
        logic [2:0] bus_wr_status;
    } ceq_fault_t;
endpackage

`default_nettype wire

// File: ceq_fifo.sv
// Sixteen-deep record FIFO with overflow latch
`default_nettype none

module ceq_fifo
#(
    parameter int DEPTH = 16,
    parameter int AW = 4
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Push side
    input wire logic push_i,
    input wire ceq_pkg::ceq_rec_t push_rec_i,
    // Pop and overflow clear
    input wire logic pop_i,
    input wire logic ovf_clr_i,
    // State
    output ceq_pkg::ceq_rec_t head_o,
    output logic [AW:0] count_o,
    output logic ovf_o,
    output logic accepted_o
);
    import ceq_pkg::*;

    ceq_rec_t mem [DEPTH]; // Record storage
    logic [AW-1:0] rd_ptr; // Oldest entry
    logic [AW-1:0] wr_ptr; // Next free slot
    logic full; // No room left
    logic empty; // Nothing held
    logic do_push; // Record really enqueued
    logic do_pop; // Head really removed

    assign full = (count_o == (AW+1)'(DEPTH));
    assign empty = (count_o == '0);
    // Latched overflow blocks pushes even with room
    assign do_push = push_i && !full && !ovf_o;
    assign do_pop = pop_i && !empty;
    assign accepted_o = do_push;

    // Head reads zero when empty
    assign head_o = empty ? '0 : mem[rd_ptr];

    // Storage write
    always_ff @(posedge clk_i)
    begin
        if (do_push)
        begin
            mem[wr_ptr] <= push_rec_i;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count_o <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop)
            begin
                count_o <= count_o + 1'b1;
            end
            else if (do_pop && !do_push)
            begin
                count_o <= count_o - 1'b1;
            end
        end
    end

    // Overflow latch, set wins over clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ovf_o <= 1'b0;
        end
        else if (push_i && (full || ovf_o))
        begin
            ovf_o <= 1'b1;
        end
        else if (ovf_clr_i)
        begin
            ovf_o <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// File: ceq_channel.sv
// One channel's fault coding, error queue, Wishbone slave and frame recovery
//
// The register addresses and the Wishbone slave port were decided locally.
`default_nettype none

module ceq_channel
#(
    parameter int DEPTH = 16
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Fault events and info sources
    input wire ceq_pkg::ceq_fault_t fault_i,
    input wire logic [23:0] rx_free_frame_counter_i,
    input wire logic [23:0] tx_free_frame_counter_i,
    input wire logic [7:0] active_config_id_i,
    input wire logic [7:0] fetched_frame_config_id_i,
    input wire logic [15:0] rx_frame_size_i,
    input wire logic [15:0] tx_frame_size_i,
    // Serial side, one enable pulse per serial clock
    input wire logic ser_clk_en_i,
    input wire logic frame_sync_i,
    // Error interrupt and serial status
    output logic err_int_o,
    output logic slot_en_o,
    output logic [10:0] bit_count_o,
    output logic frame_start_o
);
    import ceq_pkg::*;

    // Fault record arbitration
    logic [NUM_SRC-1:0] req; // One bit per fault source
    ceq_rec_t recs [NUM_SRC]; // Candidate records
    ceq_rec_t next_rec; // Chosen record this cycle
    logic next_push; // Some source reports
    logic [NUM_SRC-1:0] pend; // Events waiting their turn
    ceq_rec_t held [NUM_SRC]; // Record frozen while its event waits
    logic [NUM_SRC-1:0] all_req; // New plus waiting
    logic [NUM_SRC-1:0] grant; // Served this cycle
    // Queue state
    ceq_rec_t head; // Oldest record
    logic [4:0] count; // Records held
    logic ovf; // Overflow flag
    logic accepted; // Record really enqueued
    logic pop; // Head write strobe
    logic ovf_clr; // Control write clears overflow
    // Bus decode
    logic acc; // Access in progress
    logic hit_qctrl; // Queue control selected
    logic hit_qcount; // Record count selected
    logic hit_qhead; // Queue head selected
    logic hit_serctl; // Serial control selected
    logic hit_serstat; // Serial status selected
    logic [1:0] data_delay; // Programmed bit delay
    logic [10:0] frame_bits; // Programmed frame length
    // Frame tracker
    ceq_frame_state_t fstate; // Tracker state
    logic [10:0] bit_cnt; // Bit counter within frame
    logic [1:0] dly_cnt; // Delay counter

    // Fixed candidate records, one per source
    always_comb
    begin
        recs[0] = '{CODE_RX_OVR_START, rx_free_frame_counter_i};
        recs[1] = '{CODE_RX_OVR_MID, rx_free_frame_counter_i};
        recs[2] = '{CODE_RX_SIZE_OVR, {16'h0000, active_config_id_i}};
        recs[3] = '{CODE_RX_SIZE_MIN, {16'h0000, active_config_id_i}};
        recs[4] = '{CODE_TX_CID_MISM, {8'h00, active_config_id_i, fetched_frame_config_id_i}};
        recs[5] = '{CODE_TX_UND_START, tx_free_frame_counter_i};
        recs[6] = '{CODE_TX_UND_MID, tx_free_frame_counter_i};
        recs[7] = '{CODE_TX_SIZE_OVR, {16'h0000, active_config_id_i}};
        recs[8] = '{CODE_TX_SIZE_MIN, {16'h0000, active_config_id_i}};
        recs[9] = '{CODE_BUS_RD_BASE | {5'h00, fault_i.bus_rd_status}, 24'h000000};
        recs[10] = '{CODE_BUS_WR_BASE | {5'h00, fault_i.bus_wr_status}, 24'h000000};
    end

    // Event requests; min-size faults also raised by a start overrun or underrun with a frame below the minimum
    always_comb
    begin
        req[0] = fault_i.rx_ovr_start;
        req[1] = fault_i.rx_ovr_mid;
        req[2] = fault_i.rx_size_ovr;
        req[3] = fault_i.rx_size_small || (fault_i.rx_ovr_start && rx_frame_size_i < MIN_FRAME_SIZE);
        req[4] = fault_i.tx_cid_fetch && (fetched_frame_config_id_i != active_config_id_i);
        req[5] = fault_i.tx_und_start;
        req[6] = fault_i.tx_und_mid;
        req[7] = fault_i.tx_size_ovr;
        req[8] = fault_i.tx_size_small || (fault_i.tx_und_start && tx_frame_size_i < MIN_FRAME_SIZE);
        req[9] = fault_i.bus_rd_done && (fault_i.bus_rd_status != 3'h0);
        req[10] = fault_i.bus_wr_done && (fault_i.bus_wr_status != 3'h0);
    end

    // Lowest index wins; others wait so no simultaneous fault is lost
    assign all_req = req | pend;
    always_comb
    begin
        grant = '0;
        next_rec = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (all_req[i])
            begin
                grant = '0;
                grant[i] = 1'b1;
                next_rec = pend[i] ? held[i] : recs[i];
            end
        end
    end
    // Any request, new or waiting, asks for a push
    assign next_push = |all_req;

    // Pending events; a waiting event is served with the info held from its own cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend <= '0;
        end
        else
        begin
            // A repeat from a source already waiting merges into it
            pend <= all_req & ~grant;
        end
    end

    // Waiting events keep their own cycle's info; bus status is gone by service time
    for (genvar g = 0; g < NUM_SRC; g++)
    begin : g_held
        always_ff @(posedge clk_i)
        begin
            if (req[g] && !pend[g])
            begin
                held[g] <= recs[g];
            end
        end
    end

    // Error queue
    ceq_fifo #(.DEPTH(DEPTH), .AW(4)) u_fifo
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .push_i(next_push),
        .push_rec_i(next_rec),
        .pop_i(pop),
        .ovf_clr_i(ovf_clr),
        .head_o(head),
        .count_o(count),
        .ovf_o(ovf),
        .accepted_o(accepted)
    );

    // One-cycle interrupt per enqueued record
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            err_int_o <= 1'b0;
        end
        else
        begin
            // Dropped records never pulse; software sees them as overflow
            err_int_o <= accepted;
        end
    end

    // Register select, shared by the write strobes and the read mux
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] map_adr);
    begin
        reg_hit = (a == map_adr);
    end
    endfunction

    // Address decode for every mapped register
    assign hit_qctrl = reg_hit(adr_i, ADDR_QCTRL);
    assign hit_qcount = reg_hit(adr_i, ADDR_QCOUNT);
    assign hit_qhead = reg_hit(adr_i, ADDR_QHEAD);
    assign hit_serctl = reg_hit(adr_i, ADDR_SERCTL);
    assign hit_serstat = reg_hit(adr_i, ADDR_SERSTAT);

    // Wishbone: ack one cycle after the request, then drops
    assign acc = cyc_i && stb_i && !ack_o;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
        end
        else
        begin
            ack_o <= acc;
        end
    end

    // Write strobes take effect with the ack
    assign pop = ack_o && we_i && hit_qhead;
    assign ovf_clr = ack_o && we_i && hit_qctrl && sel_i[0] && dat_i[QCTRL_OVF_BIT];

    // Serial control register
    // Taken at the request edge, so a new length applies at once
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            data_delay <= RST_DATA_DELAY;
            frame_bits <= RST_FRAME_BITS;
        end
        else if (acc && we_i && hit_serctl)
        begin
            if (sel_i[0])
            begin
                data_delay <= dat_i[SERCTL_DLY_LSB +: 2];
            end
            if (sel_i[1])
            begin
                frame_bits <= dat_i[SERCTL_BITS_LSB +: 11];
            end
        end
    end

    // Read data, registered; unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_o <= '0;
        end
        else if (acc && !we_i)
        begin
            if (hit_qctrl)
            begin
                dat_o <= {31'h0, ovf};
            end
            else if (hit_qcount)
            begin
                dat_o <= {27'h0, count};
            end
            else if (hit_qhead)
            begin
                dat_o <= head;
            end
            else if (hit_serctl)
            begin
                // Delay in bits 1:0, frame length in bits 18:8
                dat_o <= {13'h0, frame_bits, 6'h0, data_delay};
            end
            else if (hit_serstat)
            begin
                // State in bits 1:0, bit counter in bits 12:2
                dat_o <= {19'h0, bit_cnt, fstate};
            end
            else
            begin
                dat_o <= '0;
            end
        end
    end

    // Frame tracker, advancing only on serial clock enables.
    // A stopped serial clock simply freezes it mid-frame, so on restore
    // the rest of that frame is counted out with syncs ignored.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fstate <= CEQ_WAIT_SYNC;
            bit_cnt <= '0;
            dly_cnt <= '0;
        end
        else if (ser_clk_en_i)
        begin
            case (fstate)
                CEQ_WAIT_SYNC:
                begin
                    // Extra clocks ignored until a sync
                    if (frame_sync_i)
                    begin
                        bit_cnt <= '0;
                        dly_cnt <= data_delay;
                        fstate <= (data_delay == 2'h0) ? CEQ_RUN : CEQ_DELAY;
                    end
                end
                CEQ_DELAY:
                begin
                    // Count out the programmed data delay
                    if (dly_cnt == 2'h1)
                    begin
                        fstate <= CEQ_RUN;
                    end
                    dly_cnt <= dly_cnt - 2'h1;
                end
                CEQ_RUN:
                begin
                    // Syncs inside the frame are ignored
                    // Greater-or-equal also ends a frame shortened mid-frame
                    if (bit_cnt >= frame_bits - 11'h1)
                    begin
                        fstate <= CEQ_FLUSH;
                    end
                    else
                    begin
                        bit_cnt <= bit_cnt + 11'h1;
                    end
                end
                CEQ_FLUSH:
                begin
                    // Frame done; on-time sync starts the next one
                    if (frame_sync_i)
                    begin
                        bit_cnt <= '0;
                        dly_cnt <= data_delay;
                        fstate <= (data_delay == 2'h0) ? CEQ_RUN : CEQ_DELAY;
                    end
                    else
                    begin
                        fstate <= CEQ_WAIT_SYNC;
                    end
                end
                default:
                begin
                    fstate <= CEQ_WAIT_SYNC;
                end
            endcase
        end
    end

    // Timeslot events only while the frame runs
    // Nothing while waiting for a sync or in the flush clock
    assign slot_en_o = (fstate == CEQ_RUN) && ser_clk_en_i;
    assign bit_count_o = bit_cnt;
    assign frame_start_o = slot_en_o && (bit_cnt == '0);
endmodule

`default_nettype wire

// File: ceq_properties.sv
// Port checker for one error queue channel
`default_nettype none
module ceq_properties
    import ceq_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Events and serial side
    input wire ceq_pkg::ceq_fault_t fault_i,
    input wire logic ser_clk_en_i,
    input wire logic frame_sync_i,
    input wire logic err_int_o,
    input wire logic slot_en_o,
    input wire logic frame_start_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Queue depth as of the previous cycle; lag matches registered read data
    logic [5:0] h;
    // Pop seen one cycle ago
    logic popd;
    // Sync seen since the last frame start
    logic armed;
    // Depth model: pushes show up as interrupt pulses
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            h <= 6'h0;
            popd <= 1'b0;
            armed <= 1'b0;
        end
        else
        begin
            h <= h + {5'h0, err_int_o} - {5'h0, popd && h != 6'h0};
            popd <= ack_o && we_i && adr_i == ADDR_QHEAD;
            armed <= (armed && !frame_start_o) || (ser_clk_en_i && frame_sync_i);
        end
    end
    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held beyond one cycle");
    chk_ack_reply: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    chk_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    chk_count_read: assert property (ack_o && !we_i && adr_i == ADDR_QCOUNT |-> dat_o == {26'h0, h})
        else $error("count read differs from records queued");
    chk_empty_head: assert property (ack_o && !we_i && adr_i == ADDR_QHEAD && h == 6'h0 |-> dat_o == 32'h0)
        else $error("empty queue head not zero");
    chk_full_drop: assert property (h == 6'h10 && !popd |-> !err_int_o)
        else $error("interrupt while queue full");
    chk_int_cause: assert property ($rose(err_int_o) |-> $past(fault_i) != '0)
        else $error("interrupt without fault");
    chk_slot_clk: assert property (slot_en_o || frame_start_o |-> ser_clk_en_i)
        else $error("serial event without serial clock");
    chk_start_sync: assert property (frame_start_o |-> armed)
        else $error("frame start without sync");
endmodule
bind ceq_channel ceq_properties u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
    .fault_i, .ser_clk_en_i, .frame_sync_i, .err_int_o, .slot_en_o, .frame_start_o);
`default_nettype wire

// File: ceq_ser_src.sv
// Serial clock enable and frame sync source for the line side
`default_nettype none
module ceq_ser_src
(
    // Clock
    input wire logic clk_i,
    // Bench control
    input wire logic run_i,
    input wire logic sync_req_i,
    // Serial side
    output logic ser_clk_en_o = 1'b0,
    output logic frame_sync_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Half-rate serial clock; stopping run_i models an outage
    always_ff @(posedge clk_i)
    begin
        ser_clk_en_o <= run_i && !ser_clk_en_o;
        // Sync spans one serial clock only
        frame_sync_o <= run_i && !ser_clk_en_o && sync_req_i;
    end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for one error queue channel
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ceq_pkg::*;
    // Design inputs
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h0;
    logic [31:0] dat_i = 32'h0;
    ceq_fault_t fault_i = '0;
    logic [23:0] rxc = 24'h0;
    logic [23:0] txc = 24'h0;
    logic [7:0] aid = 8'h0;
    logic [7:0] fid = 8'h0;
    logic run = 1'b0;
    logic sync_req = 1'b0;
    // Design outputs and serial source outputs
    logic [31:0] dat_o;
    logic ack_o;
    logic err_int_o;
    logic slot_en_o;
    logic frame_start_o;
    logic ser_clk_en_i;
    logic frame_sync_i;
    // Bench state
    int error_cnt = 0;
    int checked = 0;
    int ints = 0;
    int fs_n = 0;
    int sl_n = 0;
    integer seed = 32'h651cba97;
    logic [2:0] st;
    logic [31:0] exq[$];
    ceq_channel dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hf), .dat_i, .dat_o, .ack_o,
        .fault_i, .rx_free_frame_counter_i(rxc), .tx_free_frame_counter_i(txc), .active_config_id_i(aid),
        .fetched_frame_config_id_i(fid), .rx_frame_size_i(16'h0100), .tx_frame_size_i(16'h0100),
        .ser_clk_en_i, .frame_sync_i, .err_int_o, .slot_en_o, .bit_count_o(), .frame_start_o);
    ceq_ser_src u_src (.clk_i, .run_i(run), .sync_req_i(sync_req), .ser_clk_en_o(ser_clk_en_i),
        .frame_sync_o(frame_sync_i));
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Read results and event counts, taken at the edge the answer is sampled
    always @(posedge clk_i)
    begin
        if (ack_o === 1'b1 && we_i === 1'b0)
            chk("read", exq.size() ? exq.pop_front() : 32'hdead_0000, dat_o);
        if (!rst_i && err_int_o === 1'b1)
            ints++;
        if (!rst_i && frame_start_o === 1'b1)
            fs_n++;
        if (!rst_i && slot_en_o === 1'b1)
            sl_n++;
    end
    // Classic single cycle; held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1)
        begin
            n++;
            @(posedge clk_i);
        end
        chk("ack wait", 32'd1, n);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exq.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    // One-cycle fault pulse, then time for it to land
    task automatic fire(input int b, input logic [2:0] s);
        ceq_fault_t f;
        f = '0;
        f[16 - b] = 1'b1;
        f.bus_rd_status = s;
        f.bus_wr_status = s;
        @(posedge clk_i);
        fault_i <= f;
        @(posedge clk_i);
        fault_i <= '0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic sync();
        @(posedge clk_i);
        sync_req <= 1'b1;
        repeat (2) @(posedge clk_i);
        sync_req <= 1'b0;
    endtask
    // Expected record for source index b
    function automatic logic [31:0] rec(input int b, input logic [2:0] s);
        logic [7:0] cd [9] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h10, 8'h11, 8'h12, 8'h13, 8'h15};
        if (b > 8)
            return {(b == 9 ? 8'hf0 : 8'hf8) | {5'h0, s}, 24'h0};
        if (b < 2)
            return {cd[b], rxc};
        if (b == 5 || b == 6)
            return {cd[b], txc};
        if (b == 4)
            return {cd[b], 8'h0, aid, fid};
        return {cd[b], 16'h0, aid};
    endfunction
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, unmapped place, pop on empty
        rd(ADDR_QCTRL, 32'h0);
        rd(ADDR_SERCTL, 32'h0004_0000);
        wb(1'b1, 8'h14, 32'hffff_ffff);
        rd(8'h14, 32'h0);
        wb(1'b1, ADDR_QHEAD, 32'h0);
        rd(ADDR_QCOUNT, 32'h0);
        rd(ADDR_QHEAD, 32'h0);
        // Each source once with fresh info levels
        for (int b = 0; b < 11; b++)
        begin
            st = 3'($random(seed)) | 3'h1;
            rxc <= 24'($random(seed));
            txc <= 24'($random(seed));
            aid <= 8'($random(seed)) & 8'h7f;
            fid <= 8'($random(seed)) | 8'h80;
            fire(b, st);
            rd(ADDR_QCOUNT, 32'h1);
            rd(ADDR_QHEAD, rec(b, st));
            rd(ADDR_QHEAD, rec(b, st));
            wb(1'b1, ADDR_QHEAD, 32'h0);
        end
        chk("interrupts", 32'd11, ints);
        fid <= aid;
        fire(4, 3'h0);
        fire(9, 3'h0);
        fire(10, 3'h0);
        rd(ADDR_QCOUNT, 32'h0);
        // Two faults in one cycle are queued in turn; the waiting one keeps its status
        @(posedge clk_i);
        fault_i <= 17'h100a8;
        @(posedge clk_i);
        fault_i <= '0;
        repeat (4) @(posedge clk_i);
        rd(ADDR_QHEAD, rec(0, 3'h0));
        wb(1'b1, ADDR_QHEAD, 32'h0);
        rd(ADDR_QHEAD, rec(9, 3'h5));
        wb(1'b1, ADDR_QHEAD, 32'h0);
        // Overfill; overflow then blocks even with room
        ints = 0;
        for (int i = 0; i < 17; i++)
            fire(10, 3'(i % 7 + 1));
        rd(ADDR_QCOUNT, 32'd16);
        rd(ADDR_QCTRL, 32'h1);
        chk("interrupts", 32'd16, ints);
        wb(1'b1, ADDR_QHEAD, 32'h0);
        fire(9, 3'h3);
        rd(ADDR_QCOUNT, 32'd15);
        wb(1'b1, ADDR_QCTRL, 32'h1);
        rd(ADDR_QCTRL, 32'h0);
        fire(9, 3'h3);
        rd(ADDR_QCOUNT, 32'd16);
        // Drain oldest first, as a handler would
        for (int i = 1; i < 17; i++)
        begin
            rd(ADDR_QHEAD, i < 16 ? {8'hf8 | 8'(i % 7 + 1), 24'h0} : 32'hf300_0000);
            wb(1'b1, ADDR_QHEAD, 32'h0);
        end
        rd(ADDR_QHEAD, 32'h0);
        chk("interrupts", 32'd17, ints);
        // 16-bit frame, one clock of delay
        wb(1'b1, ADDR_SERCTL, 32'h0000_1001);
        rd(ADDR_SERCTL, 32'h0000_1001);
        run <= 1'b1;
        sync();
        repeat (10) @(posedge clk_i);
        sync();
        repeat (80) @(posedge clk_i);
        chk("frame starts", 32'd1, fs_n);
        chk("slots", 32'd16, sl_n);
        // Outage mid-frame; sync at restore is ignored
        sync();
        repeat (10) @(posedge clk_i);
        run <= 1'b0;
        repeat (60) @(posedge clk_i);
        run <= 1'b1;
        sync();
        repeat (80) @(posedge clk_i);
        chk("frame starts", 32'd2, fs_n);
        chk("slots", 32'd32, sl_n);
        sync();
        repeat (80) @(posedge clk_i);
        chk("frame starts", 32'd3, fs_n);
        complete_run();
    end
    // Hang guard, far beyond the roughly 850 cycles needed
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        complete_run();
    end
endmodule
`default_nettype wire
